// ---- hw/asp_regs.vh ----
// Register offsets, field positions, reset values and ratio tables
// for the serial audio port clocking block. Definitions only.
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// Register offsets (7-bit control address)
`define ASP_REG_PRX   7'h09
`define ASP_REG_PTX   7'h0a
`define ASP_REG_SEC   7'h0b
`define ASP_REG_SRST  7'h35
`define ASP_REG_STAT  7'h36
// Clocking register layout and reset value
`define ASP_CFG_RST   9'h002
`define ASP_MS_BIT    5
`define ASP_RATE_HI   2
`define ASP_RATE_LO   0
`define ASP_BSEL_HI   4
`define ASP_BSEL_LO   3
// Clock ratio codes and master clocks per frame
`define ASP_R128      3'h0
`define ASP_R192      3'h1
`define ASP_R256      3'h2
`define ASP_R384      3'h3
`define ASP_R512      3'h4
`define ASP_R768      3'h5
`define ASP_R1152     3'h6
`define ASP_FS_128    11'h080
`define ASP_FS_192    11'h0c0
`define ASP_FS_256    11'h100
`define ASP_FS_384    11'h180
`define ASP_FS_512    11'h200
`define ASP_FS_768    11'h300
`define ASP_FS_1152   11'h480
// Bit clock rate codes and bit clocks per frame
`define ASP_B64       2'h0
`define ASP_B32       2'h1
`define ASP_B16       2'h2
`define ASP_BSYS      2'h3
`define ASP_BPF_64    10'h040
`define ASP_BPF_32    10'h020
`define ASP_BPF_16    10'h010
`define ASP_BPF_128   10'h080
`define ASP_PER_MIN   11'h002
`define ASP_DUTY_DIV  11'h003
// Word length codes and bit counts
`define ASP_WL16      6'h10
`define ASP_WL20      6'h14
`define ASP_WL24      6'h18
`define ASP_WL32      6'h20
`endif

// ---- hw/asp_top.v ----
// Serial audio port clocking, framing and a receive FIFO.
// Assumes a decoded control write port, pins synchronous to clk,
// and clk acting as the master clock for generated port clocks.
`timescale 1ns/100ps
`include "asp_regs.vh"

// Word FIFO with valid/ready on both sides
module asp_fifo #(
  parameter W  = 33,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0]  wp_q;
  reg [AW:0]  rp_q;
  wire        full_w  = (wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire        empty_w = (wp_q == rp_q);

  assign in_ready  = ~full_w;
  assign out_valid = ~empty_w;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Pointer and storage update
  always @(posedge clk)
  begin
    if (rst)
    begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full_w)
      begin
        mem[wp_q[AW-1:0]] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty_w)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // asp_fifo

module asp_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Control register port
  input  wire        reg_wr,
  input  wire [6:0]  reg_addr,
  input  wire [8:0]  reg_wdata,
  output reg  [8:0]  reg_rdata_q,
  // Pin strap control
  input  wire        hw_mode,
  input  wire        tx_master_strap,
  // Port clock pins: 0 prim rx, 1 prim tx, 2 sec rx, 3 sec tx
  input  wire [3:0]  bclk_i,
  output wire [3:0]  bclk_o,
  output wire [3:0]  bclk_oe_n,
  input  wire [3:0]  lrclk_i,
  output wire [3:0]  lrclk_o,
  output wire [3:0]  lrclk_oe_n,
  // Serial data pins: 0 primary, 1 secondary
  input  wire [1:0]  rx_din,
  output wire [1:0]  tx_dout,
  // Format: right justified select and word length code
  input  wire [1:0]  rx_fmt_rj,
  input  wire [3:0]  rx_wl,
  input  wire [1:0]  tx_fmt_rj,
  input  wire [3:0]  tx_wl,
  // Primary receive words through FIFO
  output wire        rx0_valid,
  input  wire        rx0_ready,
  output wire [31:0] rx0_data,
  output wire        rx0_left,
  // Secondary receive words
  output reg         rx1_strobe_q,
  output reg  [31:0] rx1_data_q,
  output reg         rx1_left_q,
  // Transmit words and load pulses
  input  wire [63:0] tx_left,
  input  wire [63:0] tx_right,
  output wire [1:0]  tx_load
);
  reg  [8:0]  prx_q;
  reg  [8:0]  ptx_q;
  reg  [8:0]  sec_q;
  reg         ovf_q;
  wire [3:0]  master_w;
  wire [3:0]  rise_w;
  wire [3:0]  fall_w;
  wire [3:0]  lr_w;
  wire [1:0]  wv_w;
  wire [63:0] wd_w;
  wire [1:0]  wleft_w;
  wire        fifo_rdy_w;
  wire        srst_w = reg_wr && (reg_addr == `ASP_REG_SRST);

  // Master clocks per frame for a ratio code
  function [10:0] f_ratio;
    input [2:0] c;
    case (c)
      `ASP_R128:  f_ratio = `ASP_FS_128;
      `ASP_R192:  f_ratio = `ASP_FS_192;
      `ASP_R384:  f_ratio = `ASP_FS_384;
      `ASP_R512:  f_ratio = `ASP_FS_512;
      `ASP_R768:  f_ratio = `ASP_FS_768;
      `ASP_R1152: f_ratio = `ASP_FS_1152;
      default:    f_ratio = `ASP_FS_256;
    endcase
  endfunction

  // Bit clocks per frame
  function [9:0] f_bits;
    input [1:0]  s;
    input [2:0]  c;
    reg   [10:0] half_r;
    begin
      half_r = f_ratio(c) >> 1;
      case (s)
        `ASP_B64: f_bits = `ASP_BPF_64;
        `ASP_B32: f_bits = `ASP_BPF_32;
        `ASP_B16: f_bits = (c == `ASP_R128 || c == `ASP_R192) ?
                           `ASP_BPF_128 : `ASP_BPF_16;
        default:  f_bits = half_r[9:0];
      endcase
    end
  endfunction

  // Word length in bits
  function [5:0] f_wl;
    input [1:0] w;
    case (w)
      2'h0:    f_wl = `ASP_WL16;
      2'h1:    f_wl = `ASP_WL20;
      2'h2:    f_wl = `ASP_WL24;
      default: f_wl = `ASP_WL32;
    endcase
  endfunction

  // Clocking registers; any reset-register write restores defaults
  always @(posedge clk)
  begin
    if (rst || srst_w)
    begin
      prx_q <= `ASP_CFG_RST;
      ptx_q <= `ASP_CFG_RST;
      sec_q <= `ASP_CFG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ASP_REG_PRX)
        prx_q <= reg_wdata;
      if (reg_addr == `ASP_REG_PTX)
        ptx_q <= reg_wdata;
      if (reg_addr == `ASP_REG_SEC)
        sec_q <= reg_wdata;
    end
  end

  // Overflow flag: a new overflow wins over the clear
  always @(posedge clk)
  begin
    if (rst)
      ovf_q <= 1'b0;
    else if (wv_w[0] && !fifo_rdy_w)
      ovf_q <= 1'b1;
    else if (srst_w || (reg_wr && reg_addr == `ASP_REG_STAT))
      ovf_q <= 1'b0;
  end

  // Registered readback
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata_q <= 9'h000;
    else
      case (reg_addr)
        `ASP_REG_PRX:  reg_rdata_q <= prx_q;
        `ASP_REG_PTX:  reg_rdata_q <= ptx_q;
        `ASP_REG_SEC:  reg_rdata_q <= sec_q;
        `ASP_REG_STAT: reg_rdata_q <= {4'h0, ovf_q, master_w};
        default:       reg_rdata_q <= 9'h000;
      endcase
  end

  // Per-port clock generation and edge detection
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_clk
      reg  [10:0] mcnt_q;
      reg  [9:0]  bcnt_q;
      reg         bclk_q;
      reg         lr_q;
      reg         bprev_q;
      wire        beff;
      wire [8:0]  cfg = (g == 0) ? prx_q : (g == 1) ? ptx_q : sec_q;
      wire [2:0]  rc  = cfg[`ASP_RATE_HI:`ASP_RATE_LO];
      wire [1:0]  bs  = cfg[`ASP_BSEL_HI:`ASP_BSEL_LO];
      wire [9:0]  bpf = f_bits(bs, rc);
      wire [10:0] pr  = f_ratio(rc) / {1'b0, bpf};
      wire [10:0] per = (pr < `ASP_PER_MIN) ? `ASP_PER_MIN : pr;
      wire        tri3 = (bs == `ASP_B64) &&
                         (rc == `ASP_R192 || rc == `ASP_R1152);
      wire [10:0] hi  = tri3 ? per / `ASP_DUTY_DIV : per >> 1;
      // Wrap at or past the end so a shorter new period never runs away
      wire [10:0] mcnt_d = (mcnt_q >= per - 1'b1) ? 11'h000 :
                           mcnt_q + 1'b1;
      wire        fall_ev = (mcnt_d == hi);
      assign master_w[g] = cfg[`ASP_MS_BIT] ||
        ((g == 1) && hw_mode && tx_master_strap);
      // Master divider: frame clock changes only with a bit clock fall
      always @(posedge clk)
      begin
        if (rst)
        begin
          mcnt_q <= 11'h000;
          bcnt_q <= 10'h000;
          bclk_q <= 1'b1;
          lr_q   <= 1'b1;
        end
        else
        begin
          mcnt_q <= mcnt_d;
          bclk_q <= (mcnt_d < hi);
          if (fall_ev)
          begin
            if (bcnt_q >= (bpf >> 1) - 1'b1)
            begin
              bcnt_q <= 10'h000;
              lr_q   <= ~lr_q;
            end
            else
              bcnt_q <= bcnt_q + 1'b1;
          end
        end
      end
      // Master drives pins, slave takes them
      assign bclk_o[g]     = bclk_q;
      assign lrclk_o[g]    = lr_q;
      assign bclk_oe_n[g]  = ~master_w[g];
      assign lrclk_oe_n[g] = ~master_w[g];
      assign beff   = master_w[g] ? bclk_q : bclk_i[g];
      assign lr_w[g] = master_w[g] ? lr_q : lrclk_i[g];
      always @(posedge clk)
      begin
        if (rst)
          bprev_q <= 1'b1;
        else
          bprev_q <= beff;
      end
      assign rise_w[g] = beff && !bprev_q;
      assign fall_w[g] = !beff && bprev_q;
    end
  endgenerate

  // Receivers on ports 0 and 2, transmitters on ports 1 and 3
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_dat
      reg         rlr_q;
      reg  [31:0] rsh_q;
      reg  [5:0]  rcnt_q;
      reg         wv_q;
      reg  [31:0] wd_q;
      reg         wl_q;
      reg         tlr_q;
      reg  [9:0]  fcnt_q;
      reg  [9:0]  hlen_q;
      reg  [31:0] tsh_q;
      wire [5:0]  rwl = f_wl(rx_wl[2*k+1:2*k]);
      wire [5:0]  twl = f_wl(tx_wl[2*k+1:2*k]);
      wire        rlr = lr_w[2*k];
      wire        rchg = rlr != rlr_q;
      wire [31:0] mask = 32'hffffffff >> (`ASP_WL32 - rwl);
      wire        tlr = lr_w[2*k+1];
      wire        tchg = tlr != tlr_q;
      wire [9:0]  idx = tchg ? 10'h000 : fcnt_q;
      wire [9:0]  nh  = tchg ? fcnt_q : hlen_q;
      wire        ld  = tx_fmt_rj[k] ?
                        (idx == nh - {4'h0, twl}) : tchg;
      wire [31:0] wsel = tlr ? tx_left[32*k+31:32*k] :
                               tx_right[32*k+31:32*k];
      // Receive: sample data and frame clock on rising bit clock
      always @(posedge clk)
      begin
        if (rst)
        begin
          rlr_q  <= 1'b1;
          rsh_q  <= 32'h00000000;
          rcnt_q <= 6'h00;
          wv_q   <= 1'b0;
          wd_q   <= 32'h00000000;
          wl_q   <= 1'b0;
        end
        else
        begin
          wv_q <= 1'b0;
          if (rise_w[2*k])
          begin
            rlr_q <= rlr;
            if (rx_fmt_rj[k])
            begin
              rsh_q <= {rsh_q[30:0], rx_din[k]};
              if (rchg)
              begin
                wv_q <= 1'b1;
                wd_q <= rsh_q & mask;
                wl_q <= rlr_q;
              end
            end
            else if (rchg)
            begin
              rsh_q  <= {31'h00000000, rx_din[k]};
              rcnt_q <= 6'h01;
            end
            else if (rcnt_q != 6'h00 && rcnt_q < rwl)
            begin
              rsh_q  <= {rsh_q[30:0], rx_din[k]};
              rcnt_q <= rcnt_q + 1'b1;
              if (rcnt_q + 1'b1 == rwl)
              begin
                wv_q <= 1'b1;
                wd_q <= {rsh_q[30:0], rx_din[k]};
                wl_q <= rlr;
              end
            end
          end
        end
      end
      assign wv_w[k]            = wv_q;
      assign wd_w[32*k+31:32*k] = wd_q;
      assign wleft_w[k]         = wl_q;
      // Transmit: shift MSB first on falling bit clock
      always @(posedge clk)
      begin
        if (rst)
        begin
          tlr_q  <= 1'b1;
          fcnt_q <= 10'h000;
          hlen_q <= 10'h000;
          tsh_q  <= 32'h00000000;
        end
        else if (fall_w[2*k+1])
        begin
          tlr_q <= tlr;
          if (tchg)
          begin
            fcnt_q <= 10'h001;
            hlen_q <= fcnt_q;
          end
          else
            fcnt_q <= fcnt_q + 1'b1;
          if (ld)
            tsh_q <= wsel << (`ASP_WL32 - twl);
          else
            tsh_q <= {tsh_q[30:0], 1'b0};
        end
      end
      assign tx_dout[k] = tsh_q[31];
      assign tx_load[k] = ld && fall_w[2*k+1];
    end
  endgenerate

  // Primary receive words buffered for the user side
  asp_fifo #(
    .W  (33),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wv_w[0]),
    .in_ready  (fifo_rdy_w),
    .in_data   ({wleft_w[0], wd_w[31:0]}),
    .out_valid (rx0_valid),
    .out_ready (rx0_ready),
    .out_data  ({rx0_left, rx0_data})
  );

  // Secondary receive words registered out
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx1_strobe_q <= 1'b0;
      rx1_data_q   <= 32'h00000000;
      rx1_left_q   <= 1'b0;
    end
    else
    begin
      rx1_strobe_q <= wv_w[1];
      if (wv_w[1])
      begin
        rx1_data_q <= wd_w[63:32];
        rx1_left_q <= wleft_w[1];
      end
    end
  end
endmodule // asp_top

// ---- verif/asp_link_model.sv ----
// Far-side serial audio party: makes bit and frame clocks in frames,
// sends words on din and captures the device's words from dout.
`timescale 1ns/100ps
module asp_link_model (
  // Clock
  input  wire clk,
  // Serial pins
  output reg  bclk,
  output reg  lrclk,
  output reg  din,
  input  wire dout
);
  // Words seen on dout in the last frame
  reg [31:0] cap_l;
  reg [31:0] cap_r;

  // Idle pins; bit clock stands high between frames
  initial
  begin
    bclk = 1'b1;
    lrclk = 1'b0;
    din = 1'b0;
  end

  // One half frame of n bit clocks, word placed per format
  task half(input lr, input [31:0] w, input integer n, input integer wl,
            input rj, output [31:0] cap);
    integer k;
    integer b;
  begin
    cap = 32'h0;
    for (k = 0; k < n; k = k + 1)
    begin
      b = rj ? k - (n - wl) : k;
      bclk = 1'b0;
      lrclk = lr;
      if (b >= 0 && b < wl)
        din = w[wl - 1 - b];
      else
        din = ~din;
      repeat (2) @(negedge clk);
      bclk = 1'b1;
      if (b >= 0 && b < wl)
        cap = {cap[30:0], dout};
      repeat (2) @(negedge clk);
    end
  end
  endtask

  // Left half then right half; n is at least wl
  task send(input [31:0] l, input [31:0] r, input integer n,
            input integer wl, input rj);
  begin
    @(negedge clk);
    half(1'b1, l, n, wl, rj, cap_l);
    half(1'b0, r, n, wl, rj, cap_r);
  end
  endtask
endmodule // asp_link_model

// ---- verif/asp_top_sva.sv ----
// Concurrent checks on the serial audio port clocking block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module asp_top_sva (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Control and strap
  input wire        reg_wr,
  input wire [6:0]  reg_addr,
  input wire [8:0]  reg_wdata,
  input wire        hw_mode,
  input wire        tx_master_strap,
  // Port pins
  input wire [3:0]  bclk_o,
  input wire [3:0]  bclk_oe_n,
  input wire [3:0]  lrclk_i,
  input wire [3:0]  lrclk_o,
  input wire [3:0]  lrclk_oe_n,
  input wire [1:0]  tx_dout,
  // Words
  input wire [1:0]  tx_fmt_rj,
  input wire [3:0]  tx_wl,
  input wire [63:0] tx_left,
  input wire [63:0] tx_right,
  input wire [1:0]  tx_load,
  input wire        rx0_valid,
  input wire        rx0_ready,
  input wire [31:0] rx0_data,
  input wire        rx1_strobe_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  slave_after_reset_a: assert property ($fell(rst) && !hw_mode |->
    bclk_oe_n == 4'hf && lrclk_oe_n == 4'hf) else $error("not slave");
  master_select_a: assert property (reg_wr && reg_addr == 7'h09 &&
    !hw_mode |=> bclk_oe_n[0] == ~$past(reg_wdata[5]) &&
    lrclk_oe_n[0] == ~$past(reg_wdata[5])) else $error("oe mismatch");
  soft_reset_a: assert property (reg_wr && reg_addr == 7'h35 &&
    !hw_mode |=> bclk_oe_n == 4'hf && lrclk_oe_n == 4'hf)
    else $error("soft reset failed");
  strap_master_a: assert property (hw_mode && tx_master_strap &&
    $past(hw_mode && tx_master_strap) |-> !bclk_oe_n[1] &&
    !lrclk_oe_n[1]) else $error("strap ignored");
  tx_msb_out_a: assert property (tx_load[0] && !tx_fmt_rj[0] &&
    tx_wl[1:0] == 2'h0 && bclk_oe_n[1] |=> tx_dout[0] ==
    ($past(lrclk_i[1]) ? $past(tx_left[15]) : $past(tx_right[15])))
    else $error("tx msb wrong");
  rx_word_spacing_a: assert property (rx1_strobe_q |=>
    !rx1_strobe_q [*8]) else $error("strobes too close");
  fifo_hold_a: assert property (rx0_valid && !rx0_ready |=>
    rx0_valid && $stable(rx0_data)) else $error("fifo head lost");
  lrclk_on_fall_a: assert property (!lrclk_oe_n[2] &&
    $past(!lrclk_oe_n[2]) && !$past(reg_wr) && !$past(reg_wr, 2) &&
    $changed(lrclk_o[2]) |-> $fell(bclk_o[2]))
    else $error("frame edge off fall");

  cover property (tx_load[0]);
  cover property (rx0_valid && !rx0_ready);
  cover property (!bclk_oe_n[2] && $fell(bclk_o[2]));
endmodule // asp_top_sva

bind asp_top asp_top_sva i_asp_top_sva (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .hw_mode(hw_mode), .tx_master_strap(tx_master_strap),
  .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n), .lrclk_i(lrclk_i),
  .lrclk_o(lrclk_o), .lrclk_oe_n(lrclk_oe_n), .tx_dout(tx_dout),
  .tx_fmt_rj(tx_fmt_rj), .tx_wl(tx_wl), .tx_left(tx_left),
  .tx_right(tx_right), .tx_load(tx_load), .rx0_valid(rx0_valid),
  .rx0_ready(rx0_ready), .rx0_data(rx0_data),
  .rx1_strobe_q(rx1_strobe_q));

// ---- verif/tb.sv ----
// Testbench for the serial audio port block: registers, master clock
// generation, slave framing through two link models, and the FIFO.
`timescale 1ns/100ps
module tb;
  // Bench-driven inputs
  reg         clk, rst, reg_wr, hw_mode, tx_master_strap, rx0_ready;
  reg  [6:0]  reg_addr;
  reg  [8:0]  reg_wdata;
  reg  [63:0] tx_left, tx_right;
  reg  [3:0]  wl_sel;
  // Design outputs and resolved pins
  wire [8:0]  reg_rdata_q;
  wire [3:0]  bclk_i, bclk_o, bclk_oe_n, lrclk_i, lrclk_o, lrclk_oe_n;
  wire [1:0]  rx_din, tx_dout, tx_load, mb, ml;
  wire        rx0_valid, rx0_left, rx1_strobe_q, rx1_left_q;
  wire [31:0] rx0_data, rx1_data_q;
  reg  [31:0] sec_q [0:1];
  integer     errors, checked, i, j, n;

  // Pin level from whoever drives it
  assign bclk_i = (bclk_oe_n & {mb[1], mb[1], mb[0], mb[0]}) |
                  (~bclk_oe_n & bclk_o);
  assign lrclk_i = (lrclk_oe_n & {ml[1], ml[1], ml[0], ml[0]}) |
                   (~lrclk_oe_n & lrclk_o);

  asp_top i_asp_top (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .hw_mode(hw_mode), .tx_master_strap(tx_master_strap),
    .bclk_i(bclk_i), .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n),
    .lrclk_i(lrclk_i), .lrclk_o(lrclk_o), .lrclk_oe_n(lrclk_oe_n),
    .rx_din(rx_din), .tx_dout(tx_dout), .rx_fmt_rj(2'h2), .rx_wl(wl_sel),
    .tx_fmt_rj(2'h2), .tx_wl(wl_sel), .rx0_valid(rx0_valid),
    .rx0_ready(rx0_ready), .rx0_data(rx0_data), .rx0_left(rx0_left),
    .rx1_strobe_q(rx1_strobe_q), .rx1_data_q(rx1_data_q),
    .rx1_left_q(rx1_left_q), .tx_left(tx_left), .tx_right(tx_right),
    .tx_load(tx_load));
  asp_link_model i_m0 (.clk(clk), .bclk(mb[0]), .lrclk(ml[0]),
    .din(rx_din[0]), .dout(tx_dout[0]));
  asp_link_model i_m1 (.clk(clk), .bclk(mb[1]), .lrclk(ml[1]),
    .din(rx_din[1]), .dout(tx_dout[1]));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Last secondary word seen per channel
  always @(posedge clk)
    if (rx1_strobe_q === 1'b1)
      sec_q[rx1_left_q] <= rx1_data_q;

  task test_done;
  begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task check(input string name, input [31:0] e, input [31:0] g);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  end
  endtask

  task wr(input [6:0] a, input [8:0] d);
  begin
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask

  task rd(input [6:0] a, input [8:0] e);
  begin
    @(negedge clk);
    reg_addr = a;
    repeat (2) @(negedge clk);
    check("reg_rdata_q", {23'h0, e}, {23'h0, reg_rdata_q});
  end
  endtask

  // Bounded wait until a generated port 2 clock reaches level v
  task wait_pin(input sel, input v, output integer c);
  begin
    c = 0;
    while ((sel ? lrclk_o[2] : bclk_o[2]) !== v && c < 2000)
    begin
      @(negedge clk);
      c = c + 1;
    end
    if (c == 2000)
    begin
      errors = errors + 1;
      test_done;
    end
  end
  endtask

  // Master clocks of port 2: bit clock high time, period, half frame
  task measure(input [8:0] cfg, input integer eh, input integer ep,
               input integer ef);
    integer hi;
    integer lo;
  begin
    wr(7'h0b, cfg);
    wait_pin(0, 0, n);
    wait_pin(0, 1, n);
    wait_pin(0, 0, hi);
    wait_pin(0, 1, lo);
    check("bclk high", eh, hi);
    check("bclk period", ep, hi + lo);
    wait_pin(1, ~lrclk_o[2], n);
    wait_pin(1, ~lrclk_o[2], lo);
    check("lrclk half", ef, lo);
  end
  endtask

  task pop(input [31:0] e, input el);
  begin
    @(negedge clk);
    n = 0;
    while (rx0_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (n == 200)
    begin
      errors = errors + 1;
      test_done;
    end
    check("rx0_data", e, rx0_data);
    check("rx0_left", {31'h0, el}, {31'h0, rx0_left});
    rx0_ready = 1'b1;
    @(negedge clk);
    rx0_ready = 1'b0;
  end
  endtask

  // Main sequence
  initial
  begin
    errors = 0;
    checked = 0;
    {reg_wr, hw_mode, tx_master_strap, rx0_ready} = 4'h0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
    wl_sel = 4'h0;
    tx_left = 64'h0000_6b2d_0000_91e4;
    tx_right = 64'h0000_d35a_0000_27c8;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(7'h09, 9'h002);
    rd(7'h0a, 9'h002);
    rd(7'h0b, 9'h002);
    rd(7'h20, 9'h000);
    check("bclk_oe_n", 32'hf, {28'h0, bclk_oe_n});
    wr(7'h09, 9'h020);
    rd(7'h09, 9'h020);
    check("bclk_oe_n", 32'he, {28'h0, bclk_oe_n});
    wr(7'h35, 9'h1a5);
    rd(7'h09, 9'h002);
    hw_mode = 1'b1;
    tx_master_strap = 1'b1;
    repeat (2) @(negedge clk);
    check("bclk_oe_n", 32'hd, {28'h0, bclk_oe_n});
    hw_mode = 1'b0;
    tx_master_strap = 1'b0;
    // Supported ratio and rate pairs only, every ratio code
    measure(9'h020, 1, 2, 64);
    measure(9'h021, 1, 3, 96);
    measure(9'h022, 2, 4, 128);
    measure(9'h023, 3, 6, 192);
    measure(9'h024, 4, 8, 256);
    measure(9'h025, 6, 12, 384);
    measure(9'h026, 6, 18, 576);
    measure(9'h029, 3, 6, 96);
    measure(9'h030, 1, 2, 128);
    wr(7'h35, 9'h000);
    // Warm-up frame, then flush the FIFO
    fork
      i_m0.send(32'h0, 32'h0, 20, 16, 1'b0);
      i_m1.send(32'h0, 32'h0, 20, 16, 1'b1);
    join
    rx0_ready = 1'b1;
    repeat (4) @(negedge clk);
    rx0_ready = 1'b0;
    // Nine frames with the FIFO stalled: 18 words into 16 places
    fork
      for (i = 0; i < 9; i = i + 1)
        i_m0.send(32'ha500 + i, 32'h5a00 + i, 20, 16, 1'b0);
      for (j = 0; j < 9; j = j + 1)
        i_m1.send(32'h3c00 + j, 32'hc300 + j, 20, 16, 1'b1);
    join
    check("sec left", 32'h3c08, sec_q[1]);
    check("sec right", 32'hc307, sec_q[0]);
    check("tx0 left", {16'h0, tx_left[15:0]}, i_m0.cap_l & 32'hffff);
    check("tx0 right", {16'h0, tx_right[15:0]}, i_m0.cap_r & 32'hffff);
    check("tx1 left", {16'h0, tx_left[47:32]}, i_m1.cap_l & 32'hffff);
    check("tx1 right", {16'h0, tx_right[47:32]}, i_m1.cap_r & 32'hffff);
    rd(7'h36, 9'h010);
    for (i = 0; i < 16; i = i + 1)
      pop(i[0] ? 32'h5a00 + i / 2 : 32'ha500 + i / 2, ~i[0]);
    check("rx0_valid", 32'h0, {31'h0, rx0_valid});
    wr(7'h36, 9'h000);
    rd(7'h36, 9'h000);
    // Longer words: 24-bit on the primary pair, 20-bit on the secondary
    wl_sel = 4'h6;
    tx_left = 64'h000c_6b2d_00a7_91e4;
    tx_right = 64'h0003_d35a_005e_27c8;
    fork
      repeat (2) i_m0.send(32'h00b4c3d2, 32'h004e1f07, 26, 24, 1'b0);
      repeat (2) i_m1.send(32'h0009e2b1, 32'h00036d4f, 26, 20, 1'b1);
    join
    for (i = 0; i < 4; i = i + 1)
      pop(i[0] ? 32'h004e1f07 : 32'h00b4c3d2, ~i[0]);
    check("sec left", 32'h0009e2b1, sec_q[1]);
    check("sec right", 32'h00036d4f, sec_q[0]);
    check("tx0 left", {8'h0, tx_left[23:0]}, i_m0.cap_l);
    check("tx0 right", {8'h0, tx_right[23:0]}, i_m0.cap_r);
    check("tx1 left", {12'h0, tx_left[51:32]}, i_m1.cap_l);
    check("tx1 right", {12'h0, tx_right[51:32]}, i_m1.cap_r);
    test_done;
  end
endmodule // tb
